// >>> dbr_debug_regs.sv
`timescale 1ns/1ns
`include "dbr_regs.svh"
// Overview of operation
// - Four independent address breakpoint slots, each software programmable.
// - Software breakpoint instruction raises the breakpoint exception.
// - Task switch into task with trap flag 1 raises debug exception.
// - Every debug register is 64 bits wide.
// - Legacy modes: writes zero upper half, reads return lower half only.
// - 64-bit mode moves all 64 bits; operand size ignored.
// - Access only at privilege 0, otherwise protection fault.
// - Slot writes take any value, no canonical check.
// - Enabled slot matches when its address equals a reference address.
// - Matches apply to I/O addresses too and raise a debug exception.
// - Single-step mode raises debug exception after each instruction.
// - Control-transfer mode raises debug exception on calls, jumps, interrupts, exceptions.
// - Source and destination of control transfers are captured.
// - Register numbers 4 and 5 alias status and control.
// - With debug extensions on, numbers 4 and 5 raise invalid opcode.
// - Status updated whenever an enabled condition other than a control transfer raises debug exception.
// - Status bits 15, 14, 13: task switch, single step, register access.
// - Status bits 3..0 flag slot hits, read/write.
// - On breakpoint events slot bits are set if hit, cleared otherwise.
// - Hardware never clears bits 15..13; software clears them.
// - Reserved bits 31:16, 11:4 read one; bit 12 reads zero.
// - 64-bit mode: writing ones to upper status half is protection fault.
module dbr_debug_regs #(
   parameter int SLOTS = 4,
   parameter int AW = 64
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic move_valid,
   input wire logic move_write,
   input wire logic [2:0] move_num,
   input wire logic [AW-1:0] move_wdata,
   input wire logic long_mode,
   input wire logic [1:0] current_privilege,
   input wire logic debug_ext_enable,
   input wire logic retire_valid,
   input wire logic retire_is_sw_bp,
   input wire logic single_step_en,
   input wire logic xfer_step_en,
   input wire logic xfer_valid,
   input wire logic [AW-1:0] xfer_from,
   input wire logic [AW-1:0] xfer_to,
   input wire logic task_switch,
   input wire logic task_trap_flag,
   input wire logic ref_valid,
   input wire logic [AW-1:0] ref_addr,
   output logic move_done,
   output logic [AW-1:0] move_rdata,
   output logic debug_exception,
   output logic breakpoint_exception,
   output logic protection_fault,
   output logic invalid_opcode_fault,
   output logic [AW-1:0] xfer_last_from,
   output logic [AW-1:0] xfer_last_to
);
   initial begin
      if (SLOTS != 4 || AW != 64) begin
         $error("dbr_debug_regs supports four slots of 64 bits only");
      end
   end

   // =====================================================
   // state
   typedef struct packed {
      dbr_pkg::dbr_state_t st;
      logic [SLOTS-1:0][AW-1:0] slot;
      logic [AW-1:0] status;
      logic [AW-1:0] control;
      logic done;
      logic [AW-1:0] rdata;
      logic dbg;
      logic bp;
      logic gp;
      logic ud;
      logic [AW-1:0] from_q;
      logic [AW-1:0] to_q;
   } dbr_state_all_t;

   dbr_state_all_t s_reg;
   dbr_state_all_t s_next;

   logic [SLOTS-1:0] hit;
   logic [AW-1:0] rec_from;
   logic [AW-1:0] rec_to;

   // =====================================================
   // helpers
   dbr_slot_match #(
      .SLOTS(SLOTS),
      .AW(AW)
   ) u_match (
      .slot_addr(s_reg.slot),
      .enables(s_reg.control[2*SLOTS-1:0]),
      .ref_addr(ref_addr),
      .ref_valid(ref_valid),
      .hit(hit)
   );

   dbr_xfer_rec #(
      .AW(AW)
   ) u_rec (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .xfer_valid(xfer_valid),
      .xfer_from(xfer_from),
      .xfer_to(xfer_to),
      .last_from(rec_from),
      .last_to(rec_to)
   );

   // =====================================================
   // next-state logic
   logic [2:0] num_eff;
   logic is_alias;
   logic [AW-1:0] wval;
   logic [AW-1:0] rval;
   logic step_ev;
   logic xfer_ev;
   logic task_ev;
   logic slot_ev;
   logic gd_ev;

   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      s_next.dbg = 1'b0;
      s_next.bp = 1'b0;
      s_next.gp = 1'b0;
      s_next.ud = 1'b0;
      s_next.from_q = rec_from;
      s_next.to_q = rec_to;
      is_alias = (move_num == `DBR_NUM_ALIAS_STATUS) || (move_num == `DBR_NUM_ALIAS_CONTROL);
      num_eff = move_num;
      if (move_num == `DBR_NUM_ALIAS_STATUS) begin
         num_eff = `DBR_NUM_STATUS;
      end else if (move_num == `DBR_NUM_ALIAS_CONTROL) begin
         num_eff = `DBR_NUM_CONTROL;
      end
      // legacy modes keep only the low half; long mode moves all bits
      wval = long_mode ? move_wdata : {`DBR_ZERO_HI, move_wdata[31:0]};
      case (num_eff)
         `DBR_NUM_STATUS: rval = {s_reg.status[63:32], s_reg.status[31:0] | `DBR_ST_ONES};
         `DBR_NUM_CONTROL: rval = s_reg.control;
         default: rval = s_reg.slot[num_eff[1:0]];
      endcase
      if (!long_mode) begin
         rval = {`DBR_ZERO_HI, rval[31:0]};
      end
      step_ev = retire_valid && single_step_en;
      xfer_ev = xfer_valid && xfer_step_en;
      task_ev = task_switch && task_trap_flag;
      slot_ev = |hit;
      gd_ev = 1'b0;

      case (s_reg.st)
         dbr_pkg::DBR_IDLE: begin
            if (move_valid) begin
               s_next.st = dbr_pkg::DBR_ACCESS;
            end
         end
         dbr_pkg::DBR_ACCESS: begin
            s_next.st = dbr_pkg::DBR_IDLE;
         end
         dbr_pkg::DBR_EXCEPT: begin
            s_next.st = dbr_pkg::DBR_IDLE;
         end
         default: begin
            s_next.st = dbr_pkg::DBR_IDLE;
         end
      endcase

      // register moves are decoded in the cycle they arrive
      // refused or trapped moves give no completion, only their fault pulse
      if (move_valid) begin
         if (current_privilege != `DBR_PRIV_KERNEL) begin
            s_next.gp = 1'b1;
         end else if (is_alias && debug_ext_enable) begin
            s_next.ud = 1'b1;
         end else if (s_reg.control[`DBR_CT_GD_BIT]) begin
            // general detect: trap the move, do not perform it
            gd_ev = 1'b1;
            s_next.control[`DBR_CT_GD_BIT] = 1'b0;
         end else if (!move_write) begin
            s_next.done = 1'b1;
            s_next.rdata = rval;
         end else begin
            case (num_eff)
               `DBR_NUM_STATUS: begin
                  if (long_mode && (|move_wdata[63:32])) begin
                     s_next.gp = 1'b1;
                  end else begin
                     s_next.done = 1'b1;
                     s_next.status = {`DBR_ZERO_HI, (wval[31:0] & `DBR_ST_RW_MASK) | `DBR_ST_ONES};
                  end
               end
               `DBR_NUM_CONTROL: begin
                  s_next.done = 1'b1;
                  s_next.control = wval;
               end
               default: begin
                  s_next.done = 1'b1;
                  s_next.slot[num_eff[1:0]] = wval;
               end
            endcase
         end
      end

      // status update after software write, so a same-cycle event wins
      if (slot_ev || gd_ev) begin
         s_next.status[SLOTS-1:`DBR_ST_SLOT_LSB] = hit;
      end
      if (step_ev) begin
         s_next.status[`DBR_ST_STEP_BIT] = 1'b1;
      end
      if (task_ev) begin
         s_next.status[`DBR_ST_TASK_BIT] = 1'b1;
      end
      if (gd_ev) begin
         s_next.status[`DBR_ST_ACCESS_BIT] = 1'b1;
      end
      // no path clears 15:13 except a software write
      if (slot_ev || step_ev || xfer_ev || task_ev || gd_ev) begin
         s_next.dbg = 1'b1;
         s_next.st = dbr_pkg::DBR_EXCEPT;
      end
      if (retire_valid && retire_is_sw_bp) begin
         s_next.bp = 1'b1;
      end
   end

   // =====================================================
   // registers
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         s_reg <= '{st: dbr_pkg::DBR_IDLE, slot: '0, status: `DBR_ST_RESET, control: `DBR_CT_RESET,
                    done: 1'b0, rdata: '0, dbg: 1'b0, bp: 1'b0, gp: 1'b0, ud: 1'b0,
                    from_q: '0, to_q: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign move_done = s_reg.done;
   assign move_rdata = s_reg.rdata;
   assign debug_exception = s_reg.dbg;
   assign breakpoint_exception = s_reg.bp;
   assign protection_fault = s_reg.gp;
   assign invalid_opcode_fault = s_reg.ud;
   assign xfer_last_from = s_reg.from_q;
   assign xfer_last_to = s_reg.to_q;
endmodule

// >>> dbr_debug_regs_checker.sv
`timescale 1ns/1ns
// ==========================================
// port checker for the debug register bank
module dbr_debug_regs_checker #(
   parameter int AW = 64
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic move_valid,
   input wire logic move_write,
   input wire logic [2:0] move_num,
   input wire logic long_mode,
   input wire logic [1:0] current_privilege,
   input wire logic debug_ext_enable,
   input wire logic retire_valid,
   input wire logic retire_is_sw_bp,
   input wire logic single_step_en,
   input wire logic xfer_step_en,
   input wire logic xfer_valid,
   input wire logic task_switch,
   input wire logic task_trap_flag,
   input wire logic move_done,
   input wire logic [AW-1:0] move_rdata,
   input wire logic debug_exception,
   input wire logic breakpoint_exception,
   input wire logic protection_fault,
   input wire logic invalid_opcode_fault
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // both faults are decided before general detect, so debug_exception beside the fault is only an extra
   priv_fault_a: assert property (
      move_valid && current_privilege != 2'h0 |=> !move_done && (protection_fault || debug_exception))
      else $error("unprivileged move not refused");
   fault_cause_a: assert property (
      protection_fault |-> $past(move_valid)) else $error("fault without a move");
   alias_fault_a: assert property (
      move_valid && current_privilege == 2'h0 && debug_ext_enable && move_num[2:1] == 2'b10
      |=> !move_done && (invalid_opcode_fault || debug_exception)) else $error("alias not refused");
   sw_break_a: assert property (
      retire_valid && retire_is_sw_bp |=> breakpoint_exception) else $error("sw breakpoint lost");
   single_step_a: assert property (
      retire_valid && single_step_en |=> debug_exception) else $error("step exception lost");
   task_trap_a: assert property (
      task_switch && task_trap_flag |=> debug_exception) else $error("task trap lost");
   xfer_step_a: assert property (
      xfer_valid && xfer_step_en |=> debug_exception) else $error("transfer exception lost");
   legacy_read_a: assert property (
      move_done && $past(move_valid && !move_write && !long_mode) |-> move_rdata[AW-1:32] == '0)
      else $error("legacy read upper half not zero");
endmodule
bind dbr_debug_regs dbr_debug_regs_checker #(.AW(AW)) i_chk (.clk_sys(clk_sys), .nrst(nrst),
   .move_valid(move_valid), .move_write(move_write), .move_num(move_num), .long_mode(long_mode),
   .current_privilege(current_privilege), .debug_ext_enable(debug_ext_enable), .retire_valid(retire_valid),
   .retire_is_sw_bp(retire_is_sw_bp), .single_step_en(single_step_en), .xfer_step_en(xfer_step_en),
   .xfer_valid(xfer_valid), .task_switch(task_switch), .task_trap_flag(task_trap_flag),
   .move_done(move_done), .move_rdata(move_rdata), .debug_exception(debug_exception),
   .breakpoint_exception(breakpoint_exception), .protection_fault(protection_fault),
   .invalid_opcode_fault(invalid_opcode_fault));

// >>> dbr_pipe_model.sv
`timescale 1ns/1ns
// ==========================================
// retire stream: one instruction per request cycle
module dbr_pipe_model (
   input wire logic step_req,
   input wire logic bp_req,
   output logic retire_valid,
   output logic retire_is_sw_bp
);
   assign retire_valid = step_req | bp_req;
   // the breakpoint flag only ever qualifies a retiring instruction
   assign retire_is_sw_bp = bp_req;
endmodule

// >>> dbr_pkg.sv
package dbr_pkg;
   typedef enum logic [2:0] {
      DBR_IDLE = 3'b001,
      DBR_ACCESS = 3'b010,
      DBR_EXCEPT = 3'b100
   } dbr_state_t;
   typedef enum logic [1:0] {
      DBR_FLT_NONE = 2'h0,
      DBR_FLT_PROT = 2'h1,
      DBR_FLT_UNDEF = 2'h2
   } dbr_fault_t;
endpackage

// >>> dbr_regs.svh
`ifndef DBR_REGS_SVH
`define DBR_REGS_SVH
// debug register numbers on the move port
`define DBR_NUM_SLOT0 3'h0
`define DBR_NUM_SLOT3 3'h3
`define DBR_NUM_ALIAS_STATUS 3'h4
`define DBR_NUM_ALIAS_CONTROL 3'h5
`define DBR_NUM_STATUS 3'h6
`define DBR_NUM_CONTROL 3'h7
// status field positions
`define DBR_ST_TASK_BIT 15
`define DBR_ST_STEP_BIT 14
`define DBR_ST_ACCESS_BIT 13
`define DBR_ST_SLOT_LSB 0
// status: writable bits 15:13 (sticky) and 3:0
`define DBR_ST_RW_MASK 32'h0000_E00F
// status: reserved 31:16 and 11:4 read as ones, 12 as zero
`define DBR_ST_ONES 32'hFFFF_0FF0
`define DBR_ST_RESET 64'h0000_0000_FFFF_0FF0
// control: low enable bit of slot n at 2n, global at 2n+1
`define DBR_CT_GD_BIT 13
`define DBR_CT_RESET 64'h0000_0000_0000_0400
`define DBR_PRIV_KERNEL 2'h0
`define DBR_ZERO_HI 32'h0000_0000
`endif

// >>> dbr_slot_match.sv
`timescale 1ns/1ns
`include "dbr_regs.svh"
// four address comparators against the reference address
module dbr_slot_match #(
   parameter int SLOTS = 4,
   parameter int AW = 64
) (
   input wire logic [SLOTS*AW-1:0] slot_addr,
   input wire logic [2*SLOTS-1:0] enables,
   input wire logic [AW-1:0] ref_addr,
   input wire logic ref_valid,
   output logic [SLOTS-1:0] hit
);
   generate
      for (genvar i = 0; i < SLOTS; i++) begin : g_cmp
         // either local or global enable arms the slot
         assign hit[i] = ref_valid && (enables[2*i] || enables[2*i+1])
            && (slot_addr[i*AW +: AW] == ref_addr);
      end
   endgenerate
endmodule

// >>> dbr_xfer_rec.sv
`timescale 1ns/1ns
// control-transfer source/destination capture
module dbr_xfer_rec #(
   parameter int AW = 64
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic xfer_valid,
   input wire logic [AW-1:0] xfer_from,
   input wire logic [AW-1:0] xfer_to,
   output logic [AW-1:0] last_from,
   output logic [AW-1:0] last_to
);
   typedef struct packed {
      logic [AW-1:0] from_reg;
      logic [AW-1:0] to_reg;
   } dbr_rec_t;
   dbr_rec_t r_reg;
   dbr_rec_t r_next;
   always_comb begin
      r_next = r_reg;
      if (xfer_valid) begin
         r_next.from_reg = xfer_from;
         r_next.to_reg = xfer_to;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
   assign last_from = r_reg.from_reg;
   assign last_to = r_reg.to_reg;
endmodule

// >>> debug_breakpoint_registers_tb.sv
`timescale 1ns/1ns
// ==========================================
// bench
module debug_breakpoint_registers_tb;
   logic clk_sys = 1'b0;
   logic nrst, move_valid, move_write, long_mode, debug_ext_enable, single_step_en, xfer_step_en;
   logic xfer_valid, task_switch, task_trap_flag, ref_valid, step_req, bp_req, retire_valid, retire_is_sw_bp;
   logic move_done, debug_exception, breakpoint_exception, protection_fault, invalid_opcode_fault;
   logic [2:0] move_num;
   logic [1:0] current_privilege;
   logic [63:0] move_wdata, xfer_from, xfer_to, ref_addr, move_rdata, xfer_last_from, xfer_last_to;
   int num_errors = 0;
   int checks_done = 0;
   dbr_pipe_model i_pipe (.step_req(step_req), .bp_req(bp_req), .retire_valid(retire_valid),
      .retire_is_sw_bp(retire_is_sw_bp));
   dbr_debug_regs #(.SLOTS(4), .AW(64)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .move_valid(move_valid),
      .move_write(move_write), .move_num(move_num), .move_wdata(move_wdata), .long_mode(long_mode),
      .current_privilege(current_privilege), .debug_ext_enable(debug_ext_enable), .retire_valid(retire_valid),
      .retire_is_sw_bp(retire_is_sw_bp), .single_step_en(single_step_en), .xfer_step_en(xfer_step_en),
      .xfer_valid(xfer_valid), .xfer_from(xfer_from), .xfer_to(xfer_to), .task_switch(task_switch),
      .task_trap_flag(task_trap_flag), .ref_valid(ref_valid), .ref_addr(ref_addr), .move_done(move_done),
      .move_rdata(move_rdata), .debug_exception(debug_exception), .breakpoint_exception(breakpoint_exception),
      .protection_fault(protection_fault), .invalid_opcode_fault(invalid_opcode_fault),
      .xfer_last_from(xfer_last_from), .xfer_last_to(xfer_last_to));
   initial forever #2 clk_sys = ~clk_sys;
   // ==========================================
   // shared tasks, all entered at a falling edge
   task summarize;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task mv(input logic w, input logic [2:0] n, input logic [63:0] d);
      // one idle cycle first, so valid never drops and rises in one time step
      @(negedge clk_sys);
      move_valid = 1'b1;
      move_write = w;
      move_num = n;
      move_wdata = d;
      @(negedge clk_sys);
      move_valid = 1'b0;
   endtask
   task rd(input logic [2:0] n, input logic [63:0] exp);
      mv(1'b0, n, 64'h0);
      chk(move_done, 1'b1);
      chk(move_rdata, exp);
   endtask
   // ==========================================
   // scenarios
   task t_regs;
      rd(3'h6, 64'hFFFF_0FF0);
      rd(3'h7, 64'h400);
      mv(1'b1, 3'h0, 64'hDEAD_BEEF_0000_1234);
      rd(3'h0, 64'hDEAD_BEEF_0000_1234);
      long_mode = 1'b0;
      mv(1'b1, 3'h1, 64'hFFFF_FFFF_8000_0010);
      rd(3'h0, 64'h1234);
      long_mode = 1'b1;
      rd(3'h1, 64'h8000_0010);
   endtask
   task t_match;
      mv(1'b1, 3'h2, 64'h40);
      mv(1'b1, 3'h7, 64'h410);
      ref_addr = 64'h44;
      ref_valid = 1'b1;
      @(negedge clk_sys);
      chk(debug_exception, 1'b0);
      ref_addr = 64'h40;
      @(negedge clk_sys);
      ref_valid = 1'b0;
      chk(debug_exception, 1'b1);
      rd(3'h6, 64'hFFFF_0FF4);
      rd(3'h6, 64'hFFFF_0FF4);
   endtask
   task t_events;
      single_step_en = 1'b1;
      step_req = 1'b1;
      @(negedge clk_sys);
      step_req = 1'b0;
      single_step_en = 1'b0;
      chk(debug_exception, 1'b1);
      bp_req = 1'b1;
      @(negedge clk_sys);
      bp_req = 1'b0;
      chk(breakpoint_exception, 1'b1);
      task_switch = 1'b1;
      @(negedge clk_sys);
      task_switch = 1'b0;
      chk(debug_exception, 1'b1);
      xfer_valid = 1'b1;
      @(negedge clk_sys);
      xfer_valid = 1'b0;
      chk(debug_exception, 1'b1);
      @(negedge clk_sys);
      chk(xfer_last_from, 64'h1000);
      chk(xfer_last_to, 64'h2000);
      rd(3'h6, 64'hFFFF_CFF4);
   endtask
   task t_refuse;
      mv(1'b1, 3'h6, 64'h3);
      rd(3'h6, 64'hFFFF_0FF3);
      mv(1'b1, 3'h6, 64'h1_0000_0000);
      chk(protection_fault, 1'b1);
      rd(3'h6, 64'hFFFF_0FF3);
      current_privilege = 2'h3;
      mv(1'b0, 3'h0, 64'h0);
      current_privilege = 2'h0;
      chk(protection_fault, 1'b1);
      chk(move_done, 1'b0);
      rd(3'h4, 64'hFFFF_0FF3);
      rd(3'h5, 64'h410);
      debug_ext_enable = 1'b1;
      mv(1'b0, 3'h5, 64'h0);
      debug_ext_enable = 1'b0;
      chk(invalid_opcode_fault, 1'b1);
   endtask
   task t_detect;
      mv(1'b1, 3'h7, 64'h2410);
      mv(1'b0, 3'h0, 64'h0);
      chk(move_done, 1'b0);
      chk(debug_exception, 1'b1);
      rd(3'h6, 64'hFFFF_2FF0);
      rd(3'h7, 64'h410);
   endtask
   initial begin
      {nrst, move_valid, move_write, move_num, move_wdata, debug_ext_enable, single_step_en} = '0;
      {xfer_step_en, xfer_valid, task_switch, ref_valid, ref_addr, step_req, bp_req} = '0;
      current_privilege = 2'h0;
      long_mode = 1'b1;
      task_trap_flag = 1'b1;
      xfer_step_en = 1'b1;
      xfer_from = 64'h1000;
      xfer_to = 64'h2000;
      repeat (4) @(negedge clk_sys);
      nrst = 1'b1;
      t_regs();
      t_match();
      t_events();
      t_refuse();
      t_detect();
      summarize();
   end
   // the whole run needs well under 100 cycles
   initial begin
      #2000;
      num_errors++;
      summarize();
   end
endmodule
